// ### hdl/smc_pkg.sv
// package: constants and carrier types for supply monitor and comparator
package smc_pkg;

    // ----------------------------------------------------------------
    // register bit positions
    // ----------------------------------------------------------------
    localparam int PWR_LVD_EN_BIT   = 5;
    localparam int PWR_CMP_EN_BIT   = 2;
    localparam int PWR2_RESULT_BIT  = 6;
    localparam int OSC_CMP_OE_BIT   = 6;
    localparam int CCR_POS_LSB      = 2;
    localparam int CCR_NEG_LSB      = 0;

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic       CMP_EN_RST     = 1'h0;
    localparam logic [7:0] CCR_LVD_SETUP  = 8'h0a;
    localparam logic [3:0] LVD_SEL_LOWEST = 4'h0;
    localparam logic [3:0] LVD_SEL_HIGH   = 4'hf;
    localparam int         LADDER_DEN     = 128;

    typedef enum logic [1:0] {
        SMC_POS_PORT0 = 2'b00,
        SMC_POS_PORT4 = 2'b01,
        SMC_POS_VREF  = 2'b10,
        SMC_POS_NONE  = 2'b11
    } smc_psel_e;

    typedef enum logic [1:0] {
        SMC_NEG_PORT2 = 2'b00,
        SMC_NEG_PORT5 = 2'b01,
        SMC_NEG_BGAP  = 2'b10,
        SMC_NEG_VREF  = 2'b11
    } smc_nsel_e;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 50;
    localparam int SETTLE_US      = 50;
    localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
    } smc_route_s;

    typedef struct packed {
        logic [5:0] sel;
        logic [6:0] tap_num;
    } smc_ladder_s;

endpackage

// ### hdl/smc_sync.sv
// two-stage synchroniser for asynchronous analog results
`timescale 1ns/1ps
`default_nettype none
module smc_sync
    import smc_pkg::*;
#(
    parameter int WIDTH = 2
)(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    initial
    begin
        if (WIDTH < 1)
            $error("smc_sync width must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } smc_sync_s;

    smc_sync_s st_ff;
    smc_sync_s nxt_st;

    always_comb
    begin
        nxt_st.meta = async_in;
        nxt_st.held = st_ff.meta;
    end

    // reset to 1s: a detector that is idle reads as supply good
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= '1;
        else
            st_ff <= nxt_st;
    end

    assign sync_out = st_ff.held;

endmodule
`default_nettype wire

// ### hdl/smc_ctrl.sv
// supply monitor and comparator control logic
//
// How it works
// - detector enabled with supply under threshold drives detector output low
// - 4-bit select gives 16 levels, 0000 lowest, 1111 highest
// - enabled detector trip raises flag if flag enable set; with global enable, requests service
// - live detector result readable at bit 6 of second power register
// - comparator enable at power control bit 2, resets to 0 (off)
// - halt mode forces comparator off whatever its enable bit says
// - reference ladder: span bits plus select pick one of 32 taps, 65/128 to 7/128
// - positive input: 00 port bit 0, 01 port bit 4, 10 reference
// - negative input: 00 port bit 2, 01 bit 5, 10 bandgap, 11 reference
// - comparator result shares status bit 6 with detector result
// - pad-output enable at oscillator bit 6 puts comparator on port bit 3
// - pad-output enable suppresses third PWM channel output
// - flag set on high-to-low transition of detector output
// - service requested only when flag enable and global enable both set
// - flag holds at 1 until firmware writes 0 to it
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl
    import smc_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
)(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // control bits written by software
    input  wire logic [7:0] power_control_reg,
    input  wire logic [7:0] comparator_control_reg,
    input  wire logic [7:0] oscillator_control_reg,
    input  wire logic [3:0] lvd_sel,
    input  wire logic       ref_span_high,
    input  wire logic       ref_span_low,
    input  wire logic       power_control_wr,
    input  wire logic       supply_low_irq_enable,
    input  wire logic       global_irq_enable,
    input  wire logic       flag_wr,
    input  wire logic       flag_wdata,
    input  wire logic       halt_mode,
    // analog side
    input  wire logic       lvd_raw,
    input  wire logic       cmp_raw,
    output logic            lvd_analog_en,
    output logic [3:0]      lvd_level_sel,
    output logic            cmp_analog_en,
    output smc_route_s      cmp_route,
    output smc_ladder_s     cmp_ladder,
    // pins
    input  wire logic       third_pwm_in,
    input  wire logic       third_pwm_en,
    output logic            port_b_bit_three,
    output logic            port_b_bit_three_oe,
    // status
    output logic [7:0]      power_control_reg_second,
    output logic            supply_low_irq_flag,
    output logic            supply_low_irq_req,
    output logic            result_settled
);

    initial
    begin
        if (SETTLE_CNT < 1)
            $error("smc_ctrl settle count must be at least 1");
    end

    // ----------------------------------------------------------------
    // derived control
    // ----------------------------------------------------------------
    logic low_voltage_detect_enable;
    logic comparator_enable;
    logic comparator_pad_out_enable;
    logic [1:0] positive_input_select;
    logic [1:0] negative_input_select;

    assign low_voltage_detect_enable = power_control_reg[PWR_LVD_EN_BIT];
    assign comparator_enable         = power_control_reg[PWR_CMP_EN_BIT];
    assign comparator_pad_out_enable = oscillator_control_reg[OSC_CMP_OE_BIT];
    assign positive_input_select = comparator_control_reg[CCR_POS_LSB +: 2];
    assign negative_input_select = comparator_control_reg[CCR_NEG_LSB +: 2];

    // tap numerator out of LADDER_DEN for the selected span
    function automatic logic [6:0] tap_of(input logic hi, input logic [3:0] s);
        logic [6:0] t;
        t = 7'h00;
        if (hi)
        begin
            unique case (s)
                4'h0: t = 7'd65;
                4'h1: t = 7'd62;
                4'h2: t = 7'd56;
                4'h3: t = 7'd52;
                4'h4: t = 7'd48;
                4'h5: t = 7'd44;
                4'h6: t = 7'd43;
                4'h7: t = 7'd41;
                4'h8: t = 7'd39;
                4'h9: t = 7'd37;
                4'ha: t = 7'd35;
                4'hb: t = 7'd34;
                4'hc: t = 7'd32;
                4'hd: t = 7'd31;
                4'he: t = 7'd30;
                4'hf: t = 7'd29;
            endcase
        end
        else
        begin
            unique case (s)
                4'h0: t = 7'd31;
                4'h1: t = 7'd29;
                4'h2: t = 7'd26;
                4'h3: t = 7'd23;
                4'h4: t = 7'd20;
                4'h5: t = 7'd18;
                4'h6: t = 7'd17;
                4'h7: t = 7'd16;
                4'h8: t = 7'd14;
                4'h9: t = 7'd13;
                4'ha: t = 7'd12;
                4'hb: t = 7'd11;
                4'hc: t = 7'd10;
                4'hd: t = 7'd9;
                4'he: t = 7'd8;
                4'hf: t = 7'd7;
            endcase
        end
        return t;
    endfunction

    // ----------------------------------------------------------------
    // synchronised analog results
    // ----------------------------------------------------------------
    logic [1:0] sync_q;
    logic       lvd_s;
    logic       cmp_s;

    smc_sync #(
        .WIDTH    (2)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({lvd_raw, cmp_raw}),
        .sync_out (sync_q)
    );

    assign lvd_s = sync_q[1];
    assign cmp_s = sync_q[0];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        lvd_prev;
        logic        flag;
        logic        result;
        logic        pad;
        logic        pad_oe;
        logic [3:0]  sel_seen;
        logic [31:0] settle;
    } smc_ctrl_s;

    smc_ctrl_s st_ff;
    smc_ctrl_s nxt_st;
    logic      cmp_on;
    logic      lvd_fall;

    assign cmp_on   = comparator_enable && !halt_mode;
    assign lvd_fall = low_voltage_detect_enable && st_ff.lvd_prev && !lvd_s;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.lvd_prev = low_voltage_detect_enable ? lvd_s : 1'b1;
        // hardware set wins over a firmware clear in the same cycle
        if (flag_wr && !flag_wdata)
            nxt_st.flag = 1'b0;
        if (lvd_fall && supply_low_irq_enable)
            nxt_st.flag = 1'b1;
        // comparator result shares the bit with the detector when enabled
        if (cmp_on)
            nxt_st.result = cmp_s;
        else
            nxt_st.result = low_voltage_detect_enable ? lvd_s : 1'b1;
        // pad overrides the third pwm channel while enabled
        if (comparator_pad_out_enable)
        begin
            nxt_st.pad    = cmp_on ? cmp_s : 1'b0;
            nxt_st.pad_oe = 1'b1;
        end
        else
        begin
            nxt_st.pad    = third_pwm_in;
            nxt_st.pad_oe = third_pwm_en;
        end
        // settle timer restarts on any threshold change
        nxt_st.sel_seen = lvd_sel;
        if (lvd_sel != st_ff.sel_seen
            || (power_control_wr && !low_voltage_detect_enable))
            nxt_st.settle = 32'(SETTLE_CNT);
        else if (st_ff.settle != 32'h0)
            nxt_st.settle = st_ff.settle - 32'h1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff          <= '0;
            st_ff.lvd_prev <= 1'b1;
            st_ff.result   <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        power_control_reg_second = 8'h00;
        power_control_reg_second[PWR2_RESULT_BIT] = st_ff.result;
    end

    assign lvd_analog_en       = low_voltage_detect_enable;
    assign lvd_level_sel       = lvd_sel;
    assign cmp_analog_en       = cmp_on;
    assign cmp_route.pos_sel   = positive_input_select;
    assign cmp_route.neg_sel   = negative_input_select;
    assign cmp_ladder.sel      = {ref_span_high, ref_span_low, lvd_sel};
    assign cmp_ladder.tap_num  = (ref_span_high || ref_span_low)
                                 ? tap_of(ref_span_high, lvd_sel)
                                 : 7'h00;
    assign port_b_bit_three    = st_ff.pad;
    assign port_b_bit_three_oe = st_ff.pad_oe;
    assign supply_low_irq_flag = st_ff.flag;
    assign supply_low_irq_req  = st_ff.flag && supply_low_irq_enable
                                 && global_irq_enable;
    assign result_settled      = (st_ff.settle == 32'h0);

endmodule
`default_nettype wire

// ### sim/smc_analog_model.sv
// behavioural model of the on-chip detector and comparator
`timescale 1ns/1ps
`default_nettype none
module smc_analog_model (
    input  wire logic lvd_en,
    input  wire logic cmp_en,
    input  wire logic supply_below,
    input  wire logic cmp_level,
    output logic      lvd_raw,
    output logic      cmp_raw
);
    // a disabled detector never reports a low supply
    assign lvd_raw = !(lvd_en && supply_below);
    // a comparator that is off parks its output low
    assign cmp_raw = cmp_en && cmp_level;
endmodule
`default_nettype wire

// ### sim/smc_ctrl_asserts.sv
// concurrent checks on the supply monitor / comparator control ports
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl_asserts
    import smc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] power_control_reg,
    input wire logic [7:0] comparator_control_reg,
    input wire logic [7:0] oscillator_control_reg,
    input wire logic [3:0] lvd_sel,
    input wire logic       supply_low_irq_enable,
    input wire logic       global_irq_enable,
    input wire logic       flag_wr,
    input wire logic       flag_wdata,
    input wire logic       halt_mode,
    input wire logic       lvd_raw,
    input wire logic       lvd_analog_en,
    input wire logic       cmp_analog_en,
    input wire smc_route_s cmp_route,
    input wire logic       port_b_bit_three,
    input wire logic       port_b_bit_three_oe,
    input wire logic [7:0] power_control_reg_second,
    input wire logic       supply_low_irq_flag,
    input wire logic       supply_low_irq_req,
    input wire logic       result_settled
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_trip;
        $fell(lvd_raw) && power_control_reg[PWR_LVD_EN_BIT]
            && supply_low_irq_enable;
    endsequence
    // raw must sit high long enough that no fall is still in the syncer
    sequence s_clear_quiet;
        lvd_raw [*4] ##0 (flag_wr && !flag_wdata);
    endsequence

    property p_trip_flag;
        s_trip |-> ##[2:4] supply_low_irq_flag;
    endproperty
    property p_flag_hold;
        supply_low_irq_flag && !(flag_wr && !flag_wdata)
            |=> supply_low_irq_flag;
    endproperty
    property p_flag_clr;
        s_clear_quiet |=> !supply_low_irq_flag;
    endproperty
    property p_req;
        supply_low_irq_req == (supply_low_irq_flag && supply_low_irq_enable
            && global_irq_enable);
    endproperty
    property p_lvd_en;
        lvd_analog_en == power_control_reg[PWR_LVD_EN_BIT];
    endproperty
    property p_cmp_en;
        cmp_analog_en == (power_control_reg[PWR_CMP_EN_BIT] && !halt_mode);
    endproperty
    property p_route;
        cmp_route == comparator_control_reg[3:0];
    endproperty
    property p_pad_oe;
        oscillator_control_reg[OSC_CMP_OE_BIT] |=> port_b_bit_three_oe;
    endproperty
    property p_pad_off;
        (oscillator_control_reg[OSC_CMP_OE_BIT] && !cmp_analog_en) [*3]
            |-> !port_b_bit_three;
    endproperty
    property p_settle;
        $changed(lvd_sel) |-> ##[1:2] !result_settled;
    endproperty
    property p_status;
        !power_control_reg_second[7] && power_control_reg_second[5:0] == 6'h0;
    endproperty

    a_trip_flag: assert property (p_trip_flag)
        else $error("flag not raised");
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped");
    a_flag_clr: assert property (p_flag_clr)
        else $error("flag not cleared");
    a_req: assert property (p_req)
        else $error("bad service request");
    a_lvd_en: assert property (p_lvd_en)
        else $error("bad detector enable");
    a_cmp_en: assert property (p_cmp_en)
        else $error("bad comparator enable");
    a_route: assert property (p_route)
        else $error("bad input route");
    a_pad_oe: assert property (p_pad_oe)
        else $error("pad not driven");
    a_pad_off: assert property (p_pad_off)
        else $error("pad follows other source");
    a_settle: assert property (p_settle)
        else $error("settle not restarted");
    a_status: assert property (p_status)
        else $error("status spare bits set");
endmodule

bind smc_ctrl smc_ctrl_asserts u_chk (
    .mclk                     (mclk),
    .rst_n                    (rst_n),
    .power_control_reg        (power_control_reg),
    .comparator_control_reg   (comparator_control_reg),
    .oscillator_control_reg   (oscillator_control_reg),
    .lvd_sel                  (lvd_sel),
    .supply_low_irq_enable    (supply_low_irq_enable),
    .global_irq_enable        (global_irq_enable),
    .flag_wr                  (flag_wr),
    .flag_wdata               (flag_wdata),
    .halt_mode                (halt_mode),
    .lvd_raw                  (lvd_raw),
    .lvd_analog_en            (lvd_analog_en),
    .cmp_analog_en            (cmp_analog_en),
    .cmp_route                (cmp_route),
    .port_b_bit_three         (port_b_bit_three),
    .port_b_bit_three_oe      (port_b_bit_three_oe),
    .power_control_reg_second (power_control_reg_second),
    .supply_low_irq_flag      (supply_low_irq_flag),
    .supply_low_irq_req       (supply_low_irq_req),
    .result_settled           (result_settled)
);
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the supply monitor / comparator control
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import smc_pkg::*;
    logic        mclk, rst_n, pwr_wr, ie, glob_ie, fwr, fwd, halt, hi, lo;
    logic        pin, pen, below, lvl, lvd_raw, cmp_raw, lvd_en, cmp_en;
    logic        pad, oe, flag, req, settled;
    logic [7:0]  pwr_reg, ccr, osc, st;
    logic [3:0]  sel, lsel;
    smc_route_s  route;
    smc_ladder_s ladder;
    int          miscompares = 0;
    int          n_tests = 0;

    initial
    begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end

    smc_ctrl #(.SETTLE_CNT(8)) i_smc_ctrl (.mclk(mclk), .rst_n(rst_n),
        .power_control_reg(pwr_reg), .comparator_control_reg(ccr),
        .oscillator_control_reg(osc), .lvd_sel(sel), .ref_span_high(hi),
        .ref_span_low(lo), .power_control_wr(pwr_wr),
        .supply_low_irq_enable(ie),
        .global_irq_enable(glob_ie), .flag_wr(fwr), .flag_wdata(fwd),
        .halt_mode(halt), .lvd_raw(lvd_raw), .cmp_raw(cmp_raw),
        .lvd_analog_en(lvd_en), .lvd_level_sel(lsel), .cmp_analog_en(cmp_en),
        .cmp_route(route), .cmp_ladder(ladder), .third_pwm_in(pin),
        .third_pwm_en(pen), .port_b_bit_three(pad),
        .port_b_bit_three_oe(oe), .power_control_reg_second(st),
        .supply_low_irq_flag(flag), .supply_low_irq_req(req),
        .result_settled(settled));

    smc_analog_model i_smc_analog_model (.lvd_en(lvd_en), .cmp_en(cmp_en),
        .supply_below(below), .cmp_level(lvl), .lvd_raw(lvd_raw),
        .cmp_raw(cmp_raw));

    task automatic chk(input logic [7:0] seen, exp, input string nm);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic fw(input logic d);
        fwd = d;
        fwr = 1;
        cyc(1);
        fwr = 0;
        // let an edge pass so a following write never re-raises the strobe
        cyc(1);
    endtask

    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // the whole run is well under 300 cycles
    initial
    begin
        #20000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        {pwr_reg, ccr, osc, sel, hi, lo, pwr_wr, ie, glob_ie} = '0;
        {fwr, fwd, halt, pin, pen, below, lvl} = '0;
        rst_n = 0;
        cyc(16);
        rst_n = 1;
        chk(8'(cmp_en), 8'(CMP_EN_RST), "cmp_en");
        chk(st, 8'h40, "status");
        for (int i = 0; i < 16; i++)
        begin
            ccr = 8'(i);
            sel = 4'(i);
            {hi, lo} = 2'b10;
            cyc(1);
            chk(8'(route), 8'(ccr[3:0]), "route");
            chk(8'(lsel), 8'(sel), "level");
            chk(8'(ladder.sel), {2'b00, 2'b10, sel}, "ladder");
        end
        chk(8'(ladder.tap_num), 8'd29, "tap");
        lo = 1;
        hi = 0;
        cyc(1);
        chk(8'(ladder.tap_num), 8'd7, "tap");
        // detector bring-up: threshold, control word, enable, then read
        sel = LVD_SEL_LOWEST;
        hi = 1;
        lo = 0;
        cyc(1);
        chk(8'(ladder.tap_num), 8'd65, "tap");
        ccr = CCR_LVD_SETUP;
        cyc(1);
        pwr_reg[PWR_LVD_EN_BIT] = 1;
        pwr_wr = 1;
        cyc(1);
        pwr_wr = 0;
        chk(8'(settled), 8'h0, "settled");
        cyc(12);
        chk(8'(settled), 8'h1, "settled");
        chk(st, 8'h40, "status");
        ie = 1;
        below = 1;
        cyc(4);
        chk(8'(flag), 8'h1, "flag");
        chk(8'(req), 8'h0, "req");
        chk(st, 8'h00, "status");
        glob_ie = 1;
        below = 0;
        cyc(4);
        chk(8'(req), 8'h1, "req");
        fw(1);
        chk(8'(flag), 8'h1, "flag");
        fw(0);
        chk(8'(flag), 8'h0, "flag");
        chk(8'(req), 8'h0, "req");
        ie = 0;
        below = 1;
        cyc(4);
        chk(8'(flag), 8'h0, "flag");
        pwr_reg[PWR_CMP_EN_BIT] = 1;
        lvl = 1;
        cyc(4);
        chk(st, 8'h40, "status");
        osc[OSC_CMP_OE_BIT] = 1;
        pen = 1;
        cyc(4);
        chk({6'h00, oe, pad}, 8'h3, "pad");
        lvl = 0;
        pin = 1;
        cyc(4);
        chk(st, 8'h00, "status");
        chk({6'h00, oe, pad}, 8'h2, "pad");
        // halt: comparator off, status falls back to the detector
        halt = 1;
        below = 0;
        cyc(1);
        chk(8'(cmp_en), 8'h0, "cmp_en");
        lvl = 1;
        cyc(4);
        chk({6'h00, oe, pad}, 8'h2, "pad");
        chk(st, 8'h40, "status");
        end_sim();
    end
endmodule
`default_nettype wire
